// >>> core/adcsq_top.sv
// Scan-mode decoder and ascending channel sequencer with an APB register file.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module adcsq_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter side
    input wire logic dev16,
    input wire logic conv_done,
    output logic conv_start,
    output logic [3:0] conv_chan,
    output logic use_ext_clk,
    output logic avg_on,
    output logic fifo_push,
    output logic scan_busy
);

    // ------------------------------------------------------------------
    // Registers and synchronisers
    // ------------------------------------------------------------------
    logic [3:0] mode_field;
    logic [3:0] channel_select_field;
    logic avg_req;
    logic [7:0] channel_list_low;
    logic [7:0] channel_list_high;
    logic [1:0] dev16_sync;
    logic [1:0] done_sync;
    logic done_prev;
    adcsq_pkg::adcsq_state_t state;
    logic [4:0] conv_count;
    logic [4:0] expect_count;
    logic [15:0] scan_mask;
    logic found;
    logic [3:0] pick_chan;
    logic first_pick;
    logic [3:0] pick_from;
    logic done_pulse;
    logic wr_en;
    logic start_req;

    assign done_pulse = done_sync[1] & ~done_prev;
    assign wr_en = psel & penable & pwrite;
    assign start_req = wr_en && paddr == adcsq_pkg::ADDR_CONVERT && pwdata[0];

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == adcsq_pkg::ADDR_MODE_CTRL) || (a == adcsq_pkg::ADDR_LIST_LOW)
            || (a == adcsq_pkg::ADDR_LIST_HIGH) || (a == adcsq_pkg::ADDR_STATUS)
            || (a == adcsq_pkg::ADDR_CONVERT);
    endfunction

    function automatic logic ext_mode(input logic [3:0] m);
        ext_mode = (m == adcsq_pkg::MODE_STD_EXT) || (m == adcsq_pkg::MODE_UPPER_EXT)
            || (m == adcsq_pkg::MODE_CUSTOM_EXT);
    endfunction

    // ------------------------------------------------------------------
    // Synchronisers for pins
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dev16_sync <= 2'b00;
            done_sync <= 2'b00;
            done_prev <= 1'b0;
        end else begin
            dev16_sync <= {dev16_sync[0], dev16};
            done_sync <= {done_sync[0], conv_done};
            done_prev <= done_sync[1];
        end
    end

    // ------------------------------------------------------------------
    // Mode control register
    // ------------------------------------------------------------------
    // Null codes and 0000 keep the previous mode; only the five scan codes load.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_field <= adcsq_pkg::RST_MODE;
            channel_select_field <= adcsq_pkg::RST_CHSEL;
            avg_req <= 1'b0;
        end else if (wr_en && paddr == adcsq_pkg::ADDR_MODE_CTRL
                     && !pwdata[adcsq_pkg::SEL_BIT]) begin
            if (pwdata[adcsq_pkg::MODE_LSB +: 4] >= adcsq_pkg::MODE_STD_EXT
                && pwdata[adcsq_pkg::MODE_LSB +: 4] <= adcsq_pkg::MODE_CUSTOM_EXT) begin
                mode_field <= pwdata[adcsq_pkg::MODE_LSB +: 4];
                channel_select_field <= pwdata[adcsq_pkg::CHSEL_LSB +: 4];
                avg_req <= pwdata[adcsq_pkg::AVG_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel_list_low <= adcsq_pkg::RST_LIST;
            channel_list_high <= adcsq_pkg::RST_LIST;
        end else if (wr_en && paddr == adcsq_pkg::ADDR_LIST_LOW) begin
            channel_list_low <= pwdata[7:0];
        end else if (wr_en && paddr == adcsq_pkg::ADDR_LIST_HIGH) begin
            channel_list_high <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Channel set for the selected mode
    // ------------------------------------------------------------------
    // Eight-channel parts never see channels 8 to 15 in the upper and custom scans; the standard scan ignores dev16.
    always_comb begin
        scan_mask = 16'h0000;
        expect_count = 5'h00;
        case (mode_field)
            adcsq_pkg::MODE_STD_EXT: begin
                for (int i = 0; i < 16; i++) begin
                    scan_mask[i] = (i <= int'(channel_select_field));
                end
                expect_count = 5'(channel_select_field) + 5'h01;
            end
            adcsq_pkg::MODE_UPPER_INT, adcsq_pkg::MODE_UPPER_EXT: begin
                for (int i = 0; i < 16; i++) begin
                    scan_mask[i] = (i >= int'(channel_select_field));
                end
                if (dev16_sync[1]) begin
                    expect_count = adcsq_pkg::CH16_COUNT - 5'(channel_select_field);
                end else begin
                    scan_mask[15:8] = 8'h00;
                    expect_count = (channel_select_field < 4'h8)
                        ? adcsq_pkg::CH8_COUNT - 5'(channel_select_field) : 5'h00;
                end
            end
            adcsq_pkg::MODE_CUSTOM_INT, adcsq_pkg::MODE_CUSTOM_EXT: begin
                scan_mask = {channel_list_high, channel_list_low};
                if (!dev16_sync[1]) begin
                    scan_mask[15:8] = 8'h00;
                end
                expect_count = 5'(adcsq_pkg::MAX_LIST_CONV);
            end
            default: begin
                scan_mask = 16'h0000;
                expect_count = 5'h00;
            end
        endcase
    end

    assign pick_from = first_pick ? 4'h0 : conv_chan;

    adcsq_pick u_pick (
        .chan_mask(scan_mask),
        .from_chan(pick_from),
        .from_incl(first_pick),
        .found(found),
        .chan(pick_chan)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // A scan ends when the mask runs out or the conversion cap is reached.
    logic scan_launch;
    logic done_in_scan;
    logic more_left;
    logic issue_conv;

    assign scan_launch = (state == adcsq_pkg::ADCSQ_IDLE) && start_req && found;
    assign done_in_scan = (state == adcsq_pkg::ADCSQ_SCAN) && done_pulse;
    assign more_left = found && ((conv_count + 5'h01) < expect_count);
    assign issue_conv = scan_launch || (done_in_scan && more_left);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= adcsq_pkg::ADCSQ_IDLE;
        end else begin
            case (state)
                adcsq_pkg::ADCSQ_IDLE: begin
                    if (scan_launch) begin
                        state <= adcsq_pkg::ADCSQ_SCAN;
                    end
                end
                adcsq_pkg::ADCSQ_SCAN: begin
                    if (done_in_scan && !more_left) begin
                        state <= adcsq_pkg::ADCSQ_DONE;
                    end
                end
                adcsq_pkg::ADCSQ_DONE: begin
                    state <= adcsq_pkg::ADCSQ_IDLE;
                end
                default: begin
                    state <= adcsq_pkg::ADCSQ_IDLE;
                end
            endcase
        end
    end

    // The first pick may take channel 0; later picks look strictly above the last channel.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_pick <= 1'b1;
        end else if (state == adcsq_pkg::ADCSQ_IDLE) begin
            first_pick <= !scan_launch;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_chan <= 4'h0;
        end else if (issue_conv) begin
            conv_chan <= pick_chan;
        end
    end

    // Start is a single-cycle pulse so the converter never sees one request twice.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= issue_conv;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_count <= 5'h00;
        end else if (state == adcsq_pkg::ADCSQ_IDLE) begin
            conv_count <= 5'h00;
        end else if (done_in_scan) begin
            conv_count <= conv_count + 5'h01;
        end
    end

    // Serial-clock results leave on the link, so only internal scans fill the FIFO.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_push <= 1'b0;
        end else begin
            fifo_push <= done_in_scan && !use_ext_clk;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scan_busy <= 1'b0;
        end else if (scan_launch) begin
            scan_busy <= 1'b1;
        end else if (state == adcsq_pkg::ADCSQ_DONE) begin
            scan_busy <= 1'b0;
        end
    end

    // Clock source and averaging follow the mode; external modes never average.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            use_ext_clk <= 1'b0;
            avg_on <= 1'b0;
        end else begin
            use_ext_clk <= ext_mode(mode_field);
            avg_on <= avg_req && !ext_mode(mode_field)
                && mode_field != adcsq_pkg::RST_MODE;
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    adcsq_pkg::ADDR_MODE_CTRL:
                        prdata <= {16'h0000, 1'b0, mode_field, channel_select_field, 6'h00,
                            avg_req};
                    adcsq_pkg::ADDR_LIST_LOW: prdata <= {24'h000000, channel_list_low};
                    adcsq_pkg::ADDR_LIST_HIGH: prdata <= {24'h000000, channel_list_high};
                    adcsq_pkg::ADDR_STATUS:
                        prdata <= {16'h0000, 3'h0, conv_count, conv_chan, 2'h0, avg_on, scan_busy};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // adcsq_top

// >>> core/adcsq_pkg.sv
// Package with the constants shared by the scan sequencer files.
package adcsq_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIST_LOW = 8'h04;
    localparam logic [7:0] ADDR_LIST_HIGH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_CONVERT = 8'h10;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int SEL_BIT = 15;
    localparam int MODE_LSB = 11;
    localparam int CHSEL_LSB = 7;
    localparam int AVG_BIT = 0;

    // ------------------------------------------------------------------
    // Scan mode codes
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_STD_EXT = 4'h4;
    localparam logic [3:0] MODE_UPPER_INT = 4'h5;
    localparam logic [3:0] MODE_UPPER_EXT = 4'h6;
    localparam logic [3:0] MODE_CUSTOM_INT = 4'h7;
    localparam logic [3:0] MODE_CUSTOM_EXT = 4'h8;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [3:0] RST_CHSEL = 4'h0;
    localparam logic [7:0] RST_LIST = 8'h00;
    localparam int MAX_LIST_CONV = 16;
    localparam logic [4:0] CH16_COUNT = 5'h10;
    localparam logic [4:0] CH8_COUNT = 5'h08;

    typedef enum logic [1:0] {
        ADCSQ_IDLE,
        ADCSQ_SCAN,
        ADCSQ_DONE
    } adcsq_state_t;

endpackage

// >>> core/adcsq_pick.sv
// Next-channel finder for ascending scans over a channel mask.
module adcsq_pick (
    // Inputs
    input wire logic [15:0] chan_mask,
    input wire logic [3:0] from_chan,
    input wire logic from_incl,
    // Result
    output logic found,
    output logic [3:0] chan
);

    always_comb begin
        found = 1'b0;
        chan = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (chan_mask[i]
                && ((i > int'(from_chan)) || (from_incl && i == int'(from_chan)))) begin
                found = 1'b1;
                chan = 4'(i);
            end
        end
    end

endmodule // adcsq_pick

// >>> verification/adcsq_chk.sv
// Port checker for the scan sequencer.
module adcsq_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Converter side
    input wire logic conv_start,
    input wire logic [3:0] conv_chan,
    input wire logic use_ext_clk,
    input wire logic avg_on,
    input wire logic fifo_push,
    input wire logic scan_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] last_chan;
    logic seen;
    logic [4:0] n_conv;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // History is cleared between scans, so order and length are judged per scan.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_chan <= 4'h0;
            seen <= 1'b0;
            n_conv <= 5'h00;
        end else if (conv_start) begin
            last_chan <= conv_chan;
            seen <= 1'b1;
            n_conv <= n_conv + 5'h01;
        end else if (!scan_busy) begin
            seen <= 1'b0;
            n_conv <= 5'h00;
        end
    end
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_SLVERR: assert property (pready |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
        else $error("error response wrong");
    AST_START_PULSE: assert property (conv_start |=> !conv_start)
        else $error("start not a pulse");
    AST_ASCEND: assert property (conv_start && seen |->
        conv_chan > last_chan)
        else $error("channels not ascending");
    AST_MAX16: assert property (conv_start |-> n_conv < 5'h10)
        else $error("more than sixteen conversions");
    AST_EXT_NO_AVG: assert property (use_ext_clk |-> !avg_on)
        else $error("averaging in serial clock mode");
    AST_PUSH_INT: assert property (fifo_push |-> !use_ext_clk && scan_busy)
        else $error("push outside internal scan");
    AST_CHAN_HELD: assert property (!$stable(conv_chan) |-> conv_start)
        else $error("channel moved without start");
    cover property (conv_start && use_ext_clk);
    cover property (fifo_push && avg_on);
    cover property (pready && pslverr);
endmodule // adcsq_chk

bind adcsq_top adcsq_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_chan(conv_chan), .use_ext_clk(use_ext_clk),
    .avg_on(avg_on), .fifo_push(fifo_push), .scan_busy(scan_busy));

// >>> verification/adcsq_conv_model.sv
// Converter model answering each start with a done level.
module adcsq_conv_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Control
    input wire logic conv_start,
    input wire logic slow,
    // Result
    output logic conv_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int wait_cnt;
    int hold_cnt;
    // Done stays high three cycles so it survives the two-stage synchroniser.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 0;
            hold_cnt <= 0;
            conv_done <= 1'b0;
        end else if (conv_start === 1'b1) begin
            wait_cnt <= slow ? 24 : 4;
            hold_cnt <= 0;
            conv_done <= 1'b0;
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 1) begin
            wait_cnt <= 0;
            hold_cnt <= 3;
            conv_done <= 1'b1;
        end else if (hold_cnt > 1) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            conv_done <= 1'b0;
        end
    end
endmodule // adcsq_conv_model

// >>> verification/adcsq_tb.sv
// Testbench for the scan sequencer.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dev16 = 1'b1, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, conv_done, conv_start, use_ext_clk, avg_on, fifo_push, scan_busy;
    logic [3:0] conv_chan, last;
    logic [15:0] got_m;
    logic asc_bad, ext_seen, avg_seen, er;
    int got_n, pushes;
    int err_total = 0;
    int n_compared = 0;

    always #5 ref_clk = ~ref_clk;

    adcsq_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev16(dev16), .conv_done(conv_done), .conv_start(conv_start),
        .conv_chan(conv_chan), .use_ext_clk(use_ext_clk), .avg_on(avg_on),
        .fifo_push(fifo_push), .scan_busy(scan_busy));
    adcsq_conv_model u_conv (.ref_clk(ref_clk), .rst_b(rst_b), .conv_start(conv_start),
        .slow(slow), .conv_done(conv_done));

    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) begin
            if (got_n > 0 && conv_chan <= last) asc_bad = 1'b1;
            got_m[conv_chan] = 1'b1;
            last = conv_chan;
            got_n++;
            ext_seen = use_ext_clk;
            avg_seen = avg_on;
        end
        if (fifo_push === 1'b1) pushes++;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (pready !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: no ready from the slave", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic [31:0] cw(input logic [3:0] m, input logic [3:0] n, input logic av);
        return {16'h0000, 1'b0, m, n, 6'h00, av};
    endfunction

    // Writes the control word, starts a scan and judges the channels seen.
    task scan(input logic [31:0] w, input logic d16, input logic [15:0] em, input logic ext,
              input logic av);
        int k;
        dev16 <= d16;
        apb(1'b1, adcsq_pkg::ADDR_MODE_CTRL, w);
        got_m = 16'h0000;
        got_n = 0;
        pushes = 0;
        asc_bad = 1'b0;
        apb(1'b1, adcsq_pkg::ADDR_CONVERT, 32'h1);
        k = 0;
        while (scan_busy !== 1'b0 && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 3000) begin
            err_total++;
            $display("unexpected at %0t: scan never ended", $time);
        end
        check({16'h0000, got_m}, {16'h0000, em});
        check(32'(got_n), 32'($countones(em)));
        check({31'h0, asc_bad}, 32'h0);
        check(32'(pushes), ext ? 32'h0 : 32'($countones(em)));
        check({30'h0, ext_seen, avg_seen}, {30'h0, ext, av});
    endtask

    task tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        scan(cw(adcsq_pkg::MODE_STD_EXT, 4'h1, 1'b1), 1'b1, 16'h0003, 1'b1, 1'b0);
        scan(cw(adcsq_pkg::MODE_STD_EXT, 4'hf, 1'b0), 1'b1, 16'hffff, 1'b1, 1'b0);
        slow <= 1'b1;
        scan(cw(adcsq_pkg::MODE_UPPER_INT, 4'hc, 1'b1), 1'b1, 16'hf000, 1'b0, 1'b1);
        scan(cw(adcsq_pkg::MODE_UPPER_INT, 4'h3, 1'b1), 1'b0, 16'h00f8, 1'b0, 1'b1);
        slow <= 1'b0;
        scan(cw(adcsq_pkg::MODE_UPPER_EXT, 4'h0, 1'b1), 1'b1, 16'hffff, 1'b1, 1'b0);
        apb(1'b1, adcsq_pkg::ADDR_LIST_LOW, 32'ha5);
        apb(1'b1, adcsq_pkg::ADDR_LIST_HIGH, 32'h81);
        apb(1'b0, adcsq_pkg::ADDR_LIST_LOW, 32'h0);
        check(rd, 32'ha5);
        scan(cw(adcsq_pkg::MODE_CUSTOM_INT, 4'h0, 1'b1), 1'b1, 16'h81a5, 1'b0, 1'b1);
        scan(cw(adcsq_pkg::MODE_CUSTOM_EXT, 4'h2, 1'b0), 1'b0, 16'h00a5, 1'b1, 1'b0);
        scan(cw(adcsq_pkg::MODE_STD_EXT, 4'h2, 1'b0) | 32'h8000, 1'b1, 16'h81a5, 1'b1,
             1'b0);
        scan(cw(4'ha, 4'h1, 1'b0), 1'b1, 16'h81a5, 1'b1, 1'b0);
        apb(1'b0, adcsq_pkg::ADDR_MODE_CTRL, 32'h0);
        check(rd, cw(adcsq_pkg::MODE_CUSTOM_EXT, 4'h2, 1'b0));
        apb(1'b1, adcsq_pkg::ADDR_LIST_LOW, 32'hff);
        apb(1'b1, adcsq_pkg::ADDR_LIST_HIGH, 32'hff);
        scan(cw(adcsq_pkg::MODE_CUSTOM_INT, 4'h0, 1'b0), 1'b1, 16'hffff, 1'b0, 1'b0);
        apb(1'b0, 8'h40, 32'h0);
        check({rd[30:0], er}, 32'h1);
        tally_and_finish;
    end
endmodule // testbench
